//--- hw/pir_arb_if.sv
// Carrier between the register core and the priority arbiter
`timescale 1ns/1ps
interface pir_arb_if;
  logic [pir_pkg::NSRC-1:0] req;   // Eligible sources
  pir_pkg::pir_prio_t       prio;  // Per-source priority
  logic                     hit;   // Some source won
  logic [4:0]               idx;   // Winning source slot
  logic [2:0]               lvl;   // Winning priority
  modport mgr (output req, prio, input hit, idx, lvl);
  modport arb (input req, prio, output hit, idx, lvl);
endinterface : pir_arb_if

//--- hw/pir_arbiter.sv
// Priority arbiter: highest level wins, lowest slot on a tie
`timescale 1ns/1ps
module pir_arbiter (
  pir_arb_if.arb port  // Request and result carrier
);
  // Scan from the top slot down so a tie settles on the lower slot
  always_comb
  begin
    logic       h;
    logic [4:0] x;
    logic [2:0] l;
    h = 1'b0;
    x = '0;
    l = '0;
    for (int i = pir_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (port.req[i] && (!h || port.prio[i] >= l))
      begin
        h = 1'b1;  // RQ17
        x = 5'(i);
        l = port.prio[i];
      end
    end
    port.hit = h;
    port.idx = x;
    port.lvl = l;
  end
endmodule : pir_arbiter

//--- hw/pir_ctrl_top.sv
// Prioritized interrupt register block with AXI4-Lite access
// Operation
// RQ1 - Hardware sets flags; only software write clears
// RQ2 - Source interrupts only while enabled
// RQ3 - Each source has an eight-level priority
// RQ4 - Latch vector 7 bits, level 4 bits
// RQ5 - Latched level equals pending source priority
// RQ6 - Bit positions follow vector order from 8
// RQ7 - CPU level low bits at status 7:5
// RQ8 - Top level bit read-only in core word
// RQ9 - Level field binary; 111 blocks user sources
// RQ10 - Level is top over field; top masks all
// RQ11 - Nesting off freezes software level writes
// RQ12 - Top bit reads level above seven
// RQ13 - Control b: external edges, alternate table
// RQ14 - Control a: nesting off and trap bits
// RQ15 - Thirty registers: controls, arrays, pending latch; the code maps 15 of these (2 controls, 12 array words, 1 latch)
// RQ16 - Nesting off blocks preemption inside handler
// RQ17 - Forward enabled flag above CPU level
// RQ18 - Reset clears flags, enables, latch, level
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module pir_ctrl_top (
  input  wire logic        aclk,          // System clock, 125 MHz
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic        awvalid,       // Write address valid
  output logic             awready,       // Write address ready
  input  wire logic [7:0]  awaddr,        // Write byte address
  input  wire logic        wvalid,        // Write data valid
  output logic             wready,        // Write data ready
  input  wire logic [31:0] wdata,         // Write data
  input  wire logic [3:0]  wstrb,         // Write byte enables
  output logic             bvalid,        // Write response valid
  input  wire logic        bready,        // Write response ready
  output logic [1:0]       bresp,         // Write response code
  input  wire logic        arvalid,       // Read address valid
  output logic             arready,       // Read address ready
  input  wire logic [7:0]  araddr,        // Read byte address
  output logic             rvalid,        // Read data valid
  input  wire logic        rready,        // Read data ready
  output logic [31:0]      rdata,         // Read data
  output logic [1:0]       rresp,         // Read response code
  input  wire logic [31:0] src_req,       // Peripheral request set strobes
  input  wire logic [2:0]  ext_pin,       // External request pins
  input  wire logic [15:0] trap_flag_set, // Trap flag set strobes
  input  wire logic        trap_enter,    // Core enters trap level
  input  wire logic        trap_exit,     // Core leaves trap level
  input  wire logic        cpu_ack,       // Core takes pending vector
  input  wire logic        cpu_ret,       // Core returns from handler
  output logic             irq_req,       // Vector pending to core
  output logic [6:0]       irq_vector,    // pending_vector_index
  output logic [3:0]       irq_level,     // pending_level
  output logic [3:0]       cpu_level,     // Full CPU priority level
  output logic             alt_table,     // Alternate vector table
  output logic             nesting_off,   // Nesting disabled
  output logic             int_o          // Summary event interrupt
);
  // Whole module state
  typedef struct packed {
    logic                     aw_hold;   // Address captured
    logic                     w_hold;    // Data captured
    logic [7:0]               aw_addr;   // Captured address
    logic [15:0]              w_data;    // Captured data, low half
    logic [1:0]               w_strb;    // Captured lanes
    logic                     awready;   // Address ready
    logic                     wready;    // Data ready
    logic                     bvalid;    // Response pending
    logic [1:0]               bresp;     // Response code
    logic                     arready;   // Read address ready
    logic                     rvalid;    // Read data pending
    logic [1:0]               rresp;     // Read code
    logic [15:0]              rdata;     // Read word
    logic [15:0]              ctl_a;     // global_irq_control_a
    logic [15:0]              ctl_b;     // global_irq_control_b
    logic [pir_pkg::NSRC-1:0] flags;     // irq_flag_array
    logic [pir_pkg::NSRC-1:0] enables;   // irq_enable_array
    pir_pkg::pir_prio_t       prio;      // irq_priority_array
    logic [2:0]               ipl_low;   // cpu_priority_low
    logic                     ipl_top;   // cpu_priority_top
    logic [2:0]               saved_low; // Level before handler
    logic                     in_hdl;    // Handler running
    logic [6:0]               vec;       // pending_vector_index
    logic [3:0]               lvl;       // pending_level
    logic                     irq_req;   // Vector offered
    logic [2:0]               pin;       // Last pin sample
    logic [1:0]               evt;       // Sticky events
    logic [1:0]               mask;      // Event mask
    logic                     int_o;     // Interrupt out
  } pir_state_t;

  pir_state_t q_q;  // Registered state
  pir_state_t q_d;  // Next state

  pir_arb_if arb_if ();  // Arbiter carrier

  pir_arbiter u_arb (
    .port (arb_if)
  );

  // Byte lane merge under a writable mask
  function automatic logic [15:0] wmerge(
    input logic [15:0] old,
    input logic [15:0] val,
    input logic [1:0]  strb,
    input logic [15:0] wm
  );
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & wm;
    return (old & ~m) | (val & m);
  endfunction : wmerge

  // Priority word: four sources per word, three bits per nibble
  function automatic logic [15:0] prio_word(
    input pir_pkg::pir_prio_t p,
    input logic [2:0]         k
  );
    logic [15:0] w;
    w = '0;
    for (int j = 0; j < 4; j++)
    begin
      w[4*j +: 3] = p[{k, 2'(j)}];  // RQ6
    end
    return w;
  endfunction : prio_word

  // Priority word index from address, valid in range only
  function automatic logic [2:0] prio_sel(input logic [7:0] a);
    logic [7:0] off;
    off = a - pir_pkg::A_PRIO0;
    return off[4:2];
  endfunction : prio_sel

  // Address is word aligned and inside the map
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= pir_pkg::A_IMASK);  // RQ15
  endfunction : mapped

  // Read decode for one address
  function automatic logic [15:0] reg_read(
    input pir_state_t s,
    input logic [7:0] a
  );
    logic [15:0] r;
    r = '0;
    if (mapped(a) && a >= pir_pkg::A_PRIO0 && a <= pir_pkg::A_PRIO7)
    begin
      r = prio_word(s.prio, prio_sel(a));  // RQ3
    end
    else
    begin
      unique case (a)
        pir_pkg::A_CTL_A:  r = s.ctl_a;  // RQ14
        pir_pkg::A_CTL_B:  r = s.ctl_b;  // RQ13
        pir_pkg::A_FLAG0:  r = s.flags[15:0];
        pir_pkg::A_FLAG1:  r = s.flags[31:16];
        pir_pkg::A_EN0:    r = s.enables[15:0];
        pir_pkg::A_EN1:    r = s.enables[31:16];
        pir_pkg::A_PEND:   r = {4'h0, s.lvl, 1'b0, s.vec};  // RQ4
        pir_pkg::A_SR:     r[pir_pkg::IPL_LSB +: 3] = s.ipl_low;  // RQ7
        pir_pkg::A_CORE_CONTROL_WORD: r[pir_pkg::TOP_BIT] = s.ipl_top;  // RQ12
        pir_pkg::A_ISTAT:  r[1:0] = s.evt;
        pir_pkg::A_IMASK:  r[1:0] = s.mask;
        default:           r = '0;  // Unmapped or misaligned
      endcase
    end
    return r;
  endfunction : reg_read

  // Next-state logic
  always_comb
  begin
    logic [2:0]               ext_hit;
    logic [pir_pkg::NSRC-1:0] set;
    logic [pir_pkg::NSRC-1:0] elig;
    logic                     wr_go;
    logic                     clr_evt;
    logic [1:0]               new_evt;
    logic [15:0]              pw;
    logic [2:0]               k;
    q_d     = q_q;
    clr_evt = 1'b0;
    new_evt = '0;
    pw      = '0;
    k       = '0;
    ext_hit = '0;
    set     = '0;
    elig    = '0;
    wr_go   = 1'b0;
    // External pins: edge polarity from control b, 0 rising, 1 falling
    for (int i = 0; i < 3; i++)
    begin
      ext_hit[i] = q_q.ctl_b[i] ? (q_q.pin[i] & ~ext_pin[i])
                                : (~q_q.pin[i] & ext_pin[i]);  // RQ13
    end
    q_d.pin = ext_pin;
    set = src_req;
    set[pir_pkg::EXT0_SRC] = set[pir_pkg::EXT0_SRC] | ext_hit[0];  // RQ6
    set[pir_pkg::EXT1_SRC] = set[pir_pkg::EXT1_SRC] | ext_hit[1];
    set[pir_pkg::EXT2_SRC] = set[pir_pkg::EXT2_SRC] | ext_hit[2];
    // Write address and data taken independently, in either order
    if (awvalid && q_q.awready)
    begin
      q_d.aw_hold = 1'b1;
      q_d.aw_addr = awaddr;
    end
    if (wvalid && q_q.wready)
    begin
      q_d.w_hold = 1'b1;
      q_d.w_data = wdata[15:0];
      q_d.w_strb = wstrb[1:0];  // Upper lanes land in read-zero bits
    end
    if (q_q.bvalid && bready)
    begin
      q_d.bvalid = 1'b0;
    end
    wr_go = q_q.aw_hold && q_q.w_hold && !q_q.bvalid;
    if (wr_go)
    begin
      q_d.aw_hold = 1'b0;
      q_d.w_hold  = 1'b0;
      q_d.bvalid  = 1'b1;
      q_d.bresp   = mapped(q_q.aw_addr) ? pir_pkg::RESP_OKAY : pir_pkg::RESP_DECERR;
      if (mapped(q_q.aw_addr) && q_q.aw_addr >= pir_pkg::A_PRIO0 && q_q.aw_addr <= pir_pkg::A_PRIO7)
      begin
        k  = prio_sel(q_q.aw_addr);
        pw = wmerge(prio_word(q_q.prio, k), q_q.w_data, q_q.w_strb, pir_pkg::PRIO_WMASK);
        for (int j = 0; j < 4; j++)
        begin
          q_d.prio[{k, 2'(j)}] = pw[4*j +: 3];  // RQ3
        end
      end
      else
      begin
        unique case (q_q.aw_addr)
          pir_pkg::A_CTL_A:
            q_d.ctl_a = wmerge(q_q.ctl_a, q_q.w_data, q_q.w_strb, pir_pkg::CTL_A_WMASK);  // RQ14
          pir_pkg::A_CTL_B:
            q_d.ctl_b = wmerge(q_q.ctl_b, q_q.w_data, q_q.w_strb, pir_pkg::CTL_B_WMASK);  // RQ13
          pir_pkg::A_FLAG0:
            q_d.flags[15:0] = wmerge(q_q.flags[15:0], q_q.w_data, q_q.w_strb, '1);  // RQ1
          pir_pkg::A_FLAG1:
            q_d.flags[31:16] = wmerge(q_q.flags[31:16], q_q.w_data, q_q.w_strb, '1);  // RQ1
          pir_pkg::A_EN0:
            q_d.enables[15:0] = wmerge(q_q.enables[15:0], q_q.w_data, q_q.w_strb, '1);  // RQ2
          pir_pkg::A_EN1:
            q_d.enables[31:16] = wmerge(q_q.enables[31:16], q_q.w_data, q_q.w_strb, '1);
          pir_pkg::A_SR:
          begin
            // Field frozen while nesting is off
            if (!q_q.ctl_a[pir_pkg::NEST_BIT] && q_q.w_strb[0])
            begin
              q_d.ipl_low = q_q.w_data[pir_pkg::IPL_LSB +: 3];  // RQ7 RQ11
            end
          end
          pir_pkg::A_IMASK:
            q_d.mask = q_q.w_strb[0] ? q_q.w_data[1:0] : q_q.mask;
          default:
            q_d.mask = q_q.mask;  // Pending latch, core word: read only
        endcase
      end
    end
    q_d.awready = !q_d.aw_hold;
    q_d.wready  = !q_d.w_hold;
    // Hardware sets after software writes so a set wins a clear
    q_d.flags = q_d.flags | set;  // RQ1
    q_d.ctl_a = q_d.ctl_a | (trap_flag_set & pir_pkg::TRAP_SMASK);  // RQ14
    new_evt[pir_pkg::EVT_TRAP] = |(trap_flag_set & pir_pkg::TRAP_SMASK);
    // Read channel: one cycle from address to data
    if (q_q.rvalid && rready)
    begin
      q_d.rvalid = 1'b0;
    end
    if (arvalid && q_q.arready)
    begin
      q_d.rvalid = 1'b1;
      q_d.rdata  = reg_read(q_q, araddr);
      q_d.rresp  = mapped(araddr) ? pir_pkg::RESP_OKAY : pir_pkg::RESP_DECERR;
      clr_evt    = (araddr == pir_pkg::A_ISTAT);
    end
    q_d.arready = !q_d.rvalid;
    // Trap level: top bit follows the core only, never software
    if (trap_enter)
    begin
      q_d.ipl_top = 1'b1;  // RQ8 RQ10
    end
    else if (trap_exit)
    begin
      q_d.ipl_top = 1'b0;  // RQ8
    end
    // Handler entry raises the level; return restores one saved level.
    // Only one level is kept, so nested software must restore its own.
    if (q_q.irq_req && cpu_ack)
    begin
      q_d.saved_low = q_q.ipl_low;
      q_d.ipl_low   = q_q.lvl[2:0];
      q_d.in_hdl    = 1'b1;
    end
    else if (cpu_ret)
    begin
      q_d.ipl_low = q_q.saved_low;
      q_d.in_hdl  = 1'b0;
    end
    // Eligible: flagged, enabled, above the full CPU level
    for (int i = 0; i < pir_pkg::NSRC; i++)
    begin
      elig[i] = q_q.flags[i] && q_q.enables[i]
                && ({1'b0, q_q.prio[i]} > {q_q.ipl_top, q_q.ipl_low});  // RQ2 RQ9 RQ10 RQ17
    end
    arb_if.req  = elig;
    arb_if.prio = q_q.prio;
    // Offer a vector unless nesting is off inside a handler
    q_d.irq_req = arb_if.hit && !(q_q.in_hdl && q_q.ctl_a[pir_pkg::NEST_BIT])  // RQ16
                  && !(q_q.irq_req && cpu_ack);
    if (q_d.irq_req)
    begin
      q_d.vec = pir_pkg::VEC_BASE + {2'h0, arb_if.idx};  // RQ4 RQ6
      q_d.lvl = {1'b0, arb_if.lvl};  // RQ5
    end
    new_evt[pir_pkg::EVT_PEND] = q_d.irq_req && !q_q.irq_req;
    // Sticky events, cleared by reading, a new event wins
    q_d.evt   = (clr_evt ? 2'h0 : q_q.evt) | new_evt;
    q_d.int_o = |(q_d.evt & q_d.mask);
  end

  // State register, everything clears on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_q <= '0;  // RQ18
    end
    else
    begin
      q_q <= q_d;
    end
  end

  // Outputs straight from the state register
  assign awready     = q_q.awready;
  assign wready      = q_q.wready;
  assign bvalid      = q_q.bvalid;
  assign bresp       = q_q.bresp;
  assign arready     = q_q.arready;
  assign rvalid      = q_q.rvalid;
  assign rresp       = q_q.rresp;
  assign rdata       = {16'h0000, q_q.rdata};
  assign irq_req     = q_q.irq_req;
  assign irq_vector  = q_q.vec;
  assign irq_level   = q_q.lvl;
  assign cpu_level   = {q_q.ipl_top, q_q.ipl_low};  // RQ10
  assign alt_table   = q_q.ctl_b[pir_pkg::ALT_BIT];
  assign nesting_off = q_q.ctl_a[pir_pkg::NEST_BIT];
  assign int_o       = q_q.int_o;

  // Assertion helpers: previous-cycle copies, latched slot, write decodes
  logic [pir_pkg::NSRC-1:0] en_prev;   // Enables one cycle back
  logic [pir_pkg::NSRC-1:0] fl_prev;   // Flags one cycle back
  pir_pkg::pir_prio_t       pr_prev;   // Priorities one cycle back
  logic [3:0]               lv_prev;   // CPU level one cycle back
  logic [4:0]               src_of;    // Slot of latched vector
  logic                     wr_flag;   // Flag word written
  logic                     wr_sr;     // Status word written

  always_ff @(posedge aclk)
  begin
    en_prev <= q_q.enables;
    fl_prev <= q_q.flags;
    pr_prev <= q_q.prio;
    lv_prev <= {q_q.ipl_top, q_q.ipl_low};
  end

  assign src_of  = 5'(q_q.vec - pir_pkg::VEC_BASE);
  assign wr_flag = q_q.aw_hold && q_q.w_hold && !q_q.bvalid
                   && (q_q.aw_addr == pir_pkg::A_FLAG0 || q_q.aw_addr == pir_pkg::A_FLAG1);
  assign wr_sr   = q_q.aw_hold && q_q.w_hold && !q_q.bvalid && q_q.aw_addr == pir_pkg::A_SR;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_new_vec;
    $rose(q_q.irq_req);
  endsequence

  property p_flag_set;  // RQ1
    (|src_req) |=> ((q_q.flags & $past(src_req)) == $past(src_req));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("request flag not set");

  property p_flag_hold;  // RQ1
    !wr_flag |=> ((q_q.flags & $past(q_q.flags)) == $past(q_q.flags));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without write");

  property p_fwd_cause;  // RQ2
    s_new_vec |-> (en_prev[src_of] && fl_prev[src_of]);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause) else $error("vector without enabled flag");

  property p_pend_level;  // RQ5
    s_new_vec |-> (q_q.lvl == {1'b0, pr_prev[src_of]}) && (q_q.vec >= pir_pkg::VEC_BASE);
  endproperty
  a_pend_level: assert property (p_pend_level) else $error("latched level mismatch");

  property p_above_cpu;  // RQ17
    s_new_vec |-> (q_q.lvl > lv_prev);
  endproperty
  a_above_cpu: assert property (p_above_cpu) else $error("vector not above CPU level");

  property p_top_mask;  // RQ10
    q_q.ipl_top |=> !q_q.irq_req;
  endproperty
  a_top_mask: assert property (p_top_mask) else $error("user vector at trap level");

  property p_all_off;  // RQ9
    (q_q.ipl_low == 3'h7) |=> !q_q.irq_req;
  endproperty
  a_all_off: assert property (p_all_off) else $error("user vector at level seven");

  property p_nest_lock;  // RQ11
    (wr_sr && q_q.ctl_a[pir_pkg::NEST_BIT] && !cpu_ack && !cpu_ret) |=> $stable(q_q.ipl_low);
  endproperty
  a_nest_lock: assert property (p_nest_lock) else $error("level written with nesting off");

  property p_nest_block;  // RQ16
    (q_q.in_hdl && q_q.ctl_a[pir_pkg::NEST_BIT]) |=> !q_q.irq_req;
  endproperty
  a_nest_block: assert property (p_nest_block) else $error("preempted with nesting off");
endmodule : pir_ctrl_top

//--- hw/pir_pkg.sv
// Shared constants and types for the prioritized interrupt register block
package pir_pkg;
  // Source count and vector base
  localparam int         NSRC     = 32;     // User sources, vectors 8..39
  localparam logic [6:0] VEC_BASE = 7'h08;  // First user vector number
  // Register byte offsets
  localparam logic [7:0] A_CTL_A  = 8'h00;  // global_irq_control_a
  localparam logic [7:0] A_CTL_B  = 8'h04;  // global_irq_control_b
  localparam logic [7:0] A_FLAG0  = 8'h08;  // irq_flag_array word 0
  localparam logic [7:0] A_FLAG1  = 8'h0c;  // irq_flag_array word 1
  localparam logic [7:0] A_EN0    = 8'h10;  // irq_enable_array word 0
  localparam logic [7:0] A_EN1    = 8'h14;  // irq_enable_array word 1
  localparam logic [7:0] A_PRIO0  = 8'h18;  // irq_priority_array word 0
  localparam logic [7:0] A_PRIO7  = 8'h34;  // irq_priority_array word 7
  localparam logic [7:0] A_PEND   = 8'h38;  // pending_vector_latch
  localparam logic [7:0] A_SR     = 8'h3c;  // cpu_status_word
  localparam logic [7:0] A_CORE_CONTROL_WORD = 8'h40;  // core_control_word
  localparam logic [7:0] A_ISTAT  = 8'h44;  // Event status, clear on read
  localparam logic [7:0] A_IMASK  = 8'h48;  // Event mask
  // Field positions
  localparam int NEST_BIT = 15;             // nesting_off in control a
  localparam int ALT_BIT  = 15;             // Alternate table in control b
  localparam int IPL_LSB  = 5;              // cpu_priority_low in status word
  localparam int TOP_BIT  = 3;              // cpu_priority_top in core word
  localparam int PEND_LSB = 8;              // pending_level in pending latch
  localparam int EVT_PEND = 0;              // New vector latched
  localparam int EVT_TRAP = 1;              // Trap flag raised
  // Write and hardware-set masks
  localparam logic [15:0] CTL_A_WMASK = 16'hfffe; // Bit 0 unimplemented
  localparam logic [15:0] TRAP_SMASK  = 16'h78fe; // Trap flags set by hardware
  localparam logic [15:0] CTL_B_WMASK = 16'h8007; // Alt table, edge selects
  localparam logic [15:0] PRIO_WMASK  = 16'h7777; // Three bits per nibble
  // External request source slots
  localparam logic [4:0] EXT0_SRC = 5'h00;  // Vector 8
  localparam logic [4:0] EXT1_SRC = 5'h14;  // Vector 28
  localparam logic [4:0] EXT2_SRC = 5'h1d;  // Vector 37
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0; // Normal answer
  localparam logic [1:0] RESP_DECERR = 2'h3; // Unmapped address
  // Priority array type
  typedef logic [NSRC-1:0][2:0] pir_prio_t;
endpackage : pir_pkg

//--- sim/pir_core_model.sv
// Core model: takes vectors, returns from handlers
`timescale 1ns/1ps
module pir_core_model (
  input  wire logic       aclk,    // System clock
  input  wire logic       aresetn, // Sync reset, active low
  input  wire logic       irq_req, // Vector pending
  input  wire logic [3:0] dly,     // Cycles before taking a vector
  output logic            cpu_ack, // Vector taken
  output logic            cpu_ret  // Handler return
);
  // Wait, take, run a while, return
  initial
  begin
    cpu_ack = 1'b0;
    cpu_ret = 1'b0;
    forever
    begin
      @(negedge aclk);
      if (aresetn && irq_req)
      begin
        @(posedge aclk);
        repeat (dly) @(posedge aclk);
        cpu_ack <= 1'b1;
        @(posedge aclk);
        cpu_ack <= 1'b0;
        // Long handler, so software can clear the flag first
        repeat (24) @(posedge aclk);
        cpu_ret <= 1'b1;
        @(posedge aclk);
        cpu_ret <= 1'b0;
      end
    end
  end
endmodule : pir_core_model

//--- sim/test_prioritized_interrupt_registers.sv
// Self-checking interrupt block bench
`timescale 1ns/1ps
module test_prioritized_interrupt_registers;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready; // Clock, reset, write side
  logic arvalid, arready, rvalid, rready, trap_enter, trap_exit;         // Read side, trap pulses
  logic cpu_ack, cpu_ret, irq_req, alt_table, nesting_off, int_o;        // Core side and status
  logic [7:0]  awaddr, araddr;                                           // Byte addresses
  logic [31:0] wdata, rdata, src_req, rd_v;                              // Data, requests, last read
  logic [3:0]  wstrb, irq_level, cpu_level, dly;                         // Strobes, levels, model delay
  logic [1:0]  bresp, rresp, rsp;                                        // Responses
  logic [2:0]  ext_pin;                                                  // External pins
  logic [15:0] trap_flag_set;                                            // Trap set strobes
  logic [6:0]  irq_vector;                                               // Pending vector
  int n_mismatch, cmp_count, cyc;                                        // Counters
  pir_ctrl_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .src_req(src_req), .ext_pin(ext_pin), .trap_flag_set(trap_flag_set),
    .trap_enter(trap_enter), .trap_exit(trap_exit), .cpu_ack(cpu_ack), .cpu_ret(cpu_ret), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .cpu_level(cpu_level), .alt_table(alt_table),
    .nesting_off(nesting_off), .int_o(int_o));
  pir_core_model core (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .dly(dly), .cpu_ack(cpu_ack),
    .cpu_ret(cpu_ret));
  // Clock, 8 ns period
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // AXI write; address and data released each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ea, ew, b;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ea = awready && !ta;
      ew = wready && !tw;
      @(posedge aclk);
      if (ea) awvalid <= 1'b0;
      if (ew) wvalid <= 1'b0;
      ta = ta | ea;
      tw = tw | ew;
    end while (!(ta && tw));
    do
    begin
      @(negedge aclk);
      b = bvalid;
      rsp = bresp;
      @(posedge aclk);
    end while (!b);
    bready <= 1'b0;
  endtask : wr
  // AXI read; data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = rvalid;
      rd_v = rdata;
      rsp = rresp;
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask : rdc
  task automatic look();
    repeat (5) @(posedge aclk);
    @(negedge aclk);
  endtask : look
  // Bounded wait for a vector
  task automatic wait_irq();
    int i;
    for (i = 0; i < 12 && irq_req !== 1'b1; i++) @(negedge aclk);
    chk(32'(irq_req), 32'h1);
  endtask : wait_irq
  // Reset state
  task automatic t_reset();
    rdc(8'h08, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(8'h38, 32'h0);
    chk(32'(cpu_level), 32'h0);
  endtask : t_reset
  // Peripheral request, vector latch, level raise on take
  task automatic t_fire();
    wr(8'h18, 32'h5007);
    wr(8'h10, 32'h8);
    src_req <= 32'h8;
    @(posedge aclk);
    src_req <= 32'h0;
    wait_irq();
    chk(32'(irq_vector), 32'h0b);
    chk(32'(irq_level), 32'h5);
    rdc(8'h38, 32'h050b);
    chk(32'(cpu_level), 32'h5);
    rdc(8'h3c, 32'ha0);
    rdc(8'h08, 32'h8);
    wr(8'h08, 32'h0);
    repeat (30) @(posedge aclk);
  endtask : t_fire
  // External pin, enable gating, level 111 blocking
  task automatic t_mask();
    dly = 4'h6;
    wr(8'h10, 32'h0);
    ext_pin <= 3'h1;
    repeat (3) @(posedge aclk);
    ext_pin <= 3'h0;
    look();
    chk(32'(irq_req), 32'h0);
    rdc(8'h08, 32'h1);
    wr(8'h3c, 32'he0);
    wr(8'h10, 32'h1);
    look();
    chk(32'(irq_req), 32'h0);
    wr(8'h3c, 32'h0);
    wait_irq();
    chk(32'(irq_vector), 32'h08);
    chk(32'(irq_level), 32'h7);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h0);
    repeat (40) @(posedge aclk);
  endtask : t_mask
  // Nesting off freezes level writes
  task automatic t_nest();
    wr(8'h00, 32'h8000);
    look();
    chk(32'(nesting_off), 32'h1);
    wr(8'h3c, 32'he0);
    rdc(8'h3c, 32'h0);
    wr(8'h00, 32'h0);
  endtask : t_nest
  // Top level bit: read-only, set by traps, masks users
  task automatic t_trap();
    wr(8'h40, 32'h8);
    rdc(8'h40, 32'h0);
    trap_enter <= 1'b1;
    @(posedge aclk);
    trap_enter <= 1'b0;
    look();
    chk(32'(cpu_level), 32'h8);
    rdc(8'h40, 32'h8);
    wr(8'h10, 32'h8);
    wr(8'h08, 32'h8);
    look();
    chk(32'(irq_req), 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h0);
    trap_exit <= 1'b1;
    @(posedge aclk);
    trap_exit <= 1'b0;
    look();
    chk(32'(cpu_level), 32'h0);
  endtask : t_trap
  // Events, mask, summary line, table, unmapped read
  task automatic t_evt();
    rd(8'h44);
    wr(8'h48, 32'h2);
    trap_flag_set <= 16'h2;
    @(posedge aclk);
    trap_flag_set <= 16'h0;
    look();
    chk(32'(int_o), 32'h1);
    rdc(8'h44, 32'h2);
    look();
    chk(32'(int_o), 32'h0);
    rdc(8'h00, 32'h2);
    wr(8'h04, 32'h8000);
    chk(32'(rsp), 32'h0);
    look();
    chk(32'(alt_table), 32'h1);
    rd(8'h4c);
    chk(32'(rsp), 32'(pir_pkg::RESP_DECERR));
  endtask : t_evt
  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, trap_enter, trap_exit} = 7'h00;
    {awaddr, araddr, wdata, wstrb, src_req, ext_pin, trap_flag_set} = '0;
    aresetn = 1'b0; dly = 4'h0; n_mismatch = 0; cmp_count = 0; cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_fire();
    t_mask();
    t_nest();
    t_trap();
    t_evt();
    summarize();
  end
endmodule : test_prioritized_interrupt_registers
